/* File: src/mpin_cfg_pkg.sv */
// Constants and encodings shared by the multipurpose pin register logic
package mpin_cfg_pkg;

   // ==========================================================
   // Register addressing
   // ==========================================================
   localparam logic [7:0] PAGE_PIN_REGS        = 8'h00;
   localparam logic [7:0] ADDR_OUT_LEVELS      = 8'h29;
   localparam logic [7:0] ADDR_BIDIR_MONITOR   = 8'h2a;
   localparam logic [7:0] ADDR_IN_FUNCTION_A   = 8'h2b;
   localparam logic [7:0] ADDR_IN_FUNCTION_B   = 8'h2c;

   // ==========================================================
   // Reset values and writable-bit masks
   // ==========================================================
   localparam logic [7:0] RESET_OUT_LEVELS     = 8'h00;
   localparam logic [7:0] RESET_IN_FUNCTION    = 8'h00;
   localparam logic [7:0] RESET_BIDIR_MONITOR  = 8'h00;
   localparam logic [7:0] MASK_OUT_LEVELS      = 8'hf8;
   localparam logic [7:0] MASK_IN_FUNCTION     = 8'h77;
   localparam logic [7:0] READ_ZERO            = 8'h00;

   // ==========================================================
   // Field positions
   // ==========================================================
   localparam int BIT_BIDIR_LEVEL      = 7;
   localparam int BIT_OUT_PIN1_LEVEL   = 6;
   localparam int BIT_BIDIR_MONITOR    = 7;
   localparam int LSB_FUNC_HIGH        = 4;
   localparam int LSB_FUNC_LOW         = 0;
   localparam int FUNC_WIDTH           = 3;
   localparam int OUT_FUNC_WIDTH       = 4;
   localparam int NUM_IN_PINS          = 4;
   localparam int NUM_OUT_PINS         = 4;
   localparam int NUM_IN_FUNCS         = 8;

   // ==========================================================
   // Input pin function encoding
   // ==========================================================
   typedef enum logic [2:0] {
      IN_FUNC_OFF      = 3'h0,
      IN_FUNC_GENERAL  = 3'h1,
      IN_FUNC_CLOCK    = 3'h2,
      IN_FUNC_DAISY    = 3'h3,
      IN_FUNC_PDM12    = 3'h4,
      IN_FUNC_PDM34    = 3'h5,
      IN_FUNC_PDM56    = 3'h6,
      IN_FUNC_PDM78    = 3'h7
   } in_func_e;

   // ==========================================================
   // Output pin function encoding
   // ==========================================================
   typedef enum logic [3:0] {
      OUT_FUNC_OFF       = 4'h0,
      OUT_FUNC_GENERAL   = 4'h1,
      OUT_FUNC_IRQ       = 4'h2,
      OUT_FUNC_SERIAL2   = 4'h3,
      OUT_FUNC_PDM_CLOCK = 4'h4
   } out_func_e;

   // Bidirectional pin code meaning general input
   localparam logic [3:0] BIDIR_FUNC_INPUT = 4'h2;

endpackage : mpin_cfg_pkg

/* File: src/multipurpose_pin_config_value.sv */
// Register bank and pin routing for the multipurpose pins
//
// Overview of operation
// - Bit 7 of output levels sets bidirectional pin level when it is general output.
// - Bits 6..3 set output-only pins one to four levels in general output mode.
// - Output levels register at 0x29 page 0, resets zero, bits 2..0 read zero.
// - Register 0x2A bit 7 reports sampled bidirectional pin; other bits read zero.
// - Pin one field bits 6..4 at 0x2B: off, general input, clock input.
// - Function code 3 routes the pin as daisy-chain serial data input.
// - Codes 4 to 7 route the pin as PDM data for pairs 12..78.
// - Pin two field in bits 2..0 of 0x2B; bits 7 and 3 read zero.
// - Register 0x2C resets zero, holds pin three and pin four fields.
// - Pin three and four fields use the same eight-value encoding.
// - Output level reaches its pin only when the output function is 1.
`timescale 1ns/1ps
`default_nettype none
module multipurpose_pin_config_value
   import mpin_cfg_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        reset_n,
   // Control port register access
   input  wire logic [7:0]  regPage,
   input  wire logic [7:0]  regAddr,
   input  wire logic        regWrite,
   input  wire logic [7:0]  regWrData,
   input  wire logic        regRead,
   output var  logic [7:0]  regRdData,
   output var  logic        regHit,
   // Output function selections held elsewhere
   input  wire logic [3:0]  bidirPinFunction,
   input  wire logic [3:0]  outPin1Function,
   input  wire logic [3:0]  outPin2Function,
   input  wire logic [3:0]  outPin3Function,
   input  wire logic [3:0]  outPin4Function,
   // Alternate sources for output-only pins
   input  wire logic        irqLevel,
   input  wire logic        serialAudio2Out,
   input  wire logic        pdmClockOut,
   // Bidirectional pin
   input  wire logic        bidirPinIn,
   output var  logic        bidirPinOut,
   output var  logic        bidirPinOutEn_n,
   // Output-only pins, index 0 is pin one
   output var  logic [3:0]  outPinLevel,
   output var  logic [3:0]  outPinOutEn_n,
   // Input-capable pins, index 0 is pin one
   input  wire logic [3:0]  inPinRaw,
   output var  logic [3:0]  generalInputLevel,
   output var  logic        controllerClockIn,
   output var  logic        daisyChainDataInput,
   output var  logic        pdmPair12Data,
   output var  logic        pdmPair34Data,
   output var  logic        pdmPair56Data,
   output var  logic        pdmPair78Data,
   output var  logic        routeConflict
);

   // ==========================================================
   // Register storage
   // ==========================================================
   logic [7:0] pinOutputLevels;
   logic [7:0] inputPinFunctionA;
   logic [7:0] inputPinFunctionB;
   logic       bidirPinSampledLevel;

   // ==========================================================
   // Address decode
   // ==========================================================
   logic       pageHit;
   logic       hitOutLevels;
   logic       hitMonitor;
   logic       hitFunctionA;
   logic       hitFunctionB;
   logic       anyHit;
   logic       wrOutLevels;
   logic       wrFunctionA;
   logic       wrFunctionB;

   // Registers answer only on page zero at their addresses
   assign pageHit      = (regPage == PAGE_PIN_REGS);
   assign hitOutLevels = pageHit && (regAddr == ADDR_OUT_LEVELS);
   assign hitMonitor   = pageHit && (regAddr == ADDR_BIDIR_MONITOR);
   assign hitFunctionA = pageHit && (regAddr == ADDR_IN_FUNCTION_A);
   assign hitFunctionB = pageHit && (regAddr == ADDR_IN_FUNCTION_B);
   assign anyHit       = hitOutLevels || hitMonitor || hitFunctionA || hitFunctionB;

   // Write strobes; the monitor register is read-only
   assign wrOutLevels  = regWrite && hitOutLevels;
   assign wrFunctionA  = regWrite && hitFunctionA;
   assign wrFunctionB  = regWrite && hitFunctionB;

   // ==========================================================
   // Register next values with reserved bits held at zero
   // ==========================================================
   logic [7:0] next_pinOutputLevels;
   logic [7:0] next_inputPinFunctionA;
   logic [7:0] next_inputPinFunctionB;

   // Reserved bits 2..0 are masked off on every write
   assign next_pinOutputLevels = wrOutLevels
                                ? (regWrData & MASK_OUT_LEVELS)
                                : pinOutputLevels;
   // Bits 7 and 3 of both function registers stay zero
   assign next_inputPinFunctionA = wrFunctionA
                                  ? (regWrData & MASK_IN_FUNCTION)
                                  : inputPinFunctionA;
   assign next_inputPinFunctionB = wrFunctionB
                                  ? (regWrData & MASK_IN_FUNCTION)
                                  : inputPinFunctionB;

   // Writable registers
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         pinOutputLevels   <= RESET_OUT_LEVELS;
         inputPinFunctionA <= RESET_IN_FUNCTION;
         inputPinFunctionB <= RESET_IN_FUNCTION;
      end
      else
      begin
         pinOutputLevels   <= next_pinOutputLevels;
         inputPinFunctionA <= next_inputPinFunctionA;
         inputPinFunctionB <= next_inputPinFunctionB;
      end
   end

   // ==========================================================
   // Read path
   // ==========================================================
   logic [7:0] monitorWord;
   logic [7:0] readSelect;
   logic [7:0] next_regRdData;

   // Only bit 7 of the monitor word carries state
   assign monitorWord = {bidirPinSampledLevel, 7'h00};

   // Unmapped addresses and other pages read zero
   assign readSelect = hitOutLevels ? pinOutputLevels
                     : hitMonitor   ? monitorWord
                     : hitFunctionA ? inputPinFunctionA
                     : hitFunctionB ? inputPinFunctionB
                     : READ_ZERO;
   assign next_regRdData = regRead ? readSelect : regRdData;

   // Read data and hit flag, one cycle after the strobe
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         regRdData <= READ_ZERO;
         regHit    <= 1'b0;
      end
      else
      begin
         regRdData <= next_regRdData;
         regHit    <= (regRead || regWrite) && anyHit;
      end
   end

   // ==========================================================
   // Bidirectional pin
   // ==========================================================
   logic bidirPinClean;
   logic bidirIsOutput;
   logic bidirIsInput;
   logic next_bidirSampled;

   // Three stages protect the monitor bit from metastability
   pin_input_filter #(
      .WIDTH    (1)
   ) u_bidirFilter (
      .ref_clk  (ref_clk),
      .reset_n  (reset_n),
      .pinRaw   (bidirPinIn),
      .pinClean (bidirPinClean)
   );

   assign bidirIsOutput = (bidirPinFunction == OUT_FUNC_GENERAL);
   assign bidirIsInput  = (bidirPinFunction == BIDIR_FUNC_INPUT);
   // Monitor follows the pin only while it is a general input
   assign next_bidirSampled = bidirIsInput ? bidirPinClean
                                           : bidirPinSampledLevel;

   // Monitor bit and bidirectional pin drive
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         bidirPinSampledLevel <= RESET_BIDIR_MONITOR[BIT_BIDIR_MONITOR];
         bidirPinOut          <= 1'b0;
         bidirPinOutEn_n      <= 1'b1;
      end
      else
      begin
         bidirPinSampledLevel <= next_bidirSampled;
         bidirPinOut          <= pinOutputLevels[BIT_BIDIR_LEVEL];
         bidirPinOutEn_n      <= !bidirIsOutput;
      end
   end

   // ==========================================================
   // Output-only pins
   // ==========================================================
   logic [3:0] outFunc [NUM_OUT_PINS];
   logic [3:0] next_outPinLevel;
   logic [3:0] next_outPinOutEn_n;

   assign outFunc[0] = outPin1Function;
   assign outFunc[1] = outPin2Function;
   assign outFunc[2] = outPin3Function;
   assign outFunc[3] = outPin4Function;

   // Per-pin source select; level bits run from bit 6 down
   genvar op;
   generate
      for (op = 0; op < NUM_OUT_PINS; op++)
      begin : g_outPin
         logic levelBit;
         logic isGeneral;
         logic isIrq;
         logic isSerial;
         logic isPdmClk;
         assign levelBit  = pinOutputLevels[BIT_OUT_PIN1_LEVEL - op];
         assign isGeneral = (outFunc[op] == OUT_FUNC_GENERAL);
         assign isIrq     = (outFunc[op] == OUT_FUNC_IRQ);
         assign isSerial  = (outFunc[op] == OUT_FUNC_SERIAL2);
         assign isPdmClk  = (outFunc[op] == OUT_FUNC_PDM_CLOCK);
         assign next_outPinLevel[op] = (isGeneral && levelBit)
                                     | (isIrq && irqLevel)
                                     | (isSerial && serialAudio2Out)
                                     | (isPdmClk && pdmClockOut);
         // Disabled and reserved codes leave the pin undriven
         assign next_outPinOutEn_n[op] = !(isGeneral || isIrq || isSerial || isPdmClk);
      end
   endgenerate

   // Registered output-only pin drive
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         outPinLevel   <= '0;
         outPinOutEn_n <= '1;
      end
      else
      begin
         outPinLevel   <= next_outPinLevel;
         outPinOutEn_n <= next_outPinOutEn_n;
      end
   end

   // ==========================================================
   // Input-capable pins
   // ==========================================================
   logic [3:0] inPinClean;
   logic [2:0] inFunc [NUM_IN_PINS];
   logic [NUM_IN_PINS-1:0] funcSel [NUM_IN_FUNCS];

   pin_input_filter #(
      .WIDTH    (NUM_IN_PINS)
   ) u_inFilter (
      .ref_clk  (ref_clk),
      .reset_n  (reset_n),
      .pinRaw   (inPinRaw),
      .pinClean (inPinClean)
   );

   // Field extraction; all four pins share one encoding
   assign inFunc[0] = inputPinFunctionA[LSB_FUNC_HIGH +: FUNC_WIDTH];
   assign inFunc[1] = inputPinFunctionA[LSB_FUNC_LOW +: FUNC_WIDTH];
   assign inFunc[2] = inputPinFunctionB[LSB_FUNC_HIGH +: FUNC_WIDTH];
   assign inFunc[3] = inputPinFunctionB[LSB_FUNC_LOW +: FUNC_WIDTH];

   // One-hot decode of each pin's function code
   genvar fp;
   genvar fc;
   generate
      for (fc = 0; fc < NUM_IN_FUNCS; fc++)
      begin : g_func
         for (fp = 0; fp < NUM_IN_PINS; fp++)
         begin : g_pin
            assign funcSel[fc][fp] = (inFunc[fp] == 3'(fc));
         end
      end
   endgenerate

   // Lowest-numbered pin wins when several select the same role
   function automatic logic pickFirst(
      input logic [NUM_IN_PINS-1:0] sel,
      input logic [NUM_IN_PINS-1:0] data
   );
      logic found;
      logic value;
      found = 1'b0;
      value = 1'b0;
      for (int i = 0; i < NUM_IN_PINS; i++)
      begin
         if (sel[i] && !found)
         begin
            found = 1'b1;
            value = data[i];
         end
      end
      return value;
   endfunction : pickFirst

   // More than one pin claiming one routed role
   function automatic logic multiSel(
      input logic [NUM_IN_PINS-1:0] sel
   );
      return (sel & (sel - 4'h1)) != 4'h0;
   endfunction : multiSel

   logic [3:0] next_generalInput;
   logic       next_clockIn;
   logic       next_daisyIn;
   logic       next_pdm12;
   logic       next_pdm34;
   logic       next_pdm56;
   logic       next_pdm78;
   logic       next_conflict;

   // Routing of filtered pin levels to their selected consumers
   assign next_generalInput = inPinClean & funcSel[IN_FUNC_GENERAL];
   assign next_clockIn = pickFirst(funcSel[IN_FUNC_CLOCK], inPinClean);
   assign next_daisyIn = pickFirst(funcSel[IN_FUNC_DAISY], inPinClean);
   assign next_pdm12   = pickFirst(funcSel[IN_FUNC_PDM12], inPinClean);
   assign next_pdm34   = pickFirst(funcSel[IN_FUNC_PDM34], inPinClean);
   assign next_pdm56   = pickFirst(funcSel[IN_FUNC_PDM56], inPinClean);
   assign next_pdm78   = pickFirst(funcSel[IN_FUNC_PDM78], inPinClean);
   assign next_conflict = multiSel(funcSel[IN_FUNC_CLOCK])
                        | multiSel(funcSel[IN_FUNC_DAISY])
                        | multiSel(funcSel[IN_FUNC_PDM12])
                        | multiSel(funcSel[IN_FUNC_PDM34])
                        | multiSel(funcSel[IN_FUNC_PDM56])
                        | multiSel(funcSel[IN_FUNC_PDM78]);

   // Registered routed inputs
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         generalInputLevel   <= '0;
         controllerClockIn   <= 1'b0;
         daisyChainDataInput <= 1'b0;
         pdmPair12Data       <= 1'b0;
         pdmPair34Data       <= 1'b0;
         pdmPair56Data       <= 1'b0;
         pdmPair78Data       <= 1'b0;
         routeConflict       <= 1'b0;
      end
      else
      begin
         generalInputLevel   <= next_generalInput;
         controllerClockIn   <= next_clockIn;
         daisyChainDataInput <= next_daisyIn;
         pdmPair12Data       <= next_pdm12;
         pdmPair34Data       <= next_pdm34;
         pdmPair56Data       <= next_pdm56;
         pdmPair78Data       <= next_pdm78;
         routeConflict       <= next_conflict;
      end
   end

endmodule : multipurpose_pin_config_value
`default_nettype wire

/* File: src/pin_input_filter.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pin_input_filter
   import mpin_cfg_pkg::*;
#(
   parameter int WIDTH = 1
)(
   input  wire logic             ref_clk,
   input  wire logic             reset_n,
   input  wire logic [WIDTH-1:0] pinRaw,
   output var  logic [WIDTH-1:0] pinClean
);

   // ==========================================================
   // Synchroniser stages
   // ==========================================================
   logic [WIDTH-1:0] stageOne;
   logic [WIDTH-1:0] stageTwo;
   logic [WIDTH-1:0] stageThree;
   logic [WIDTH-1:0] next_pinClean;

   // A change is taken once the second and third stages agree
   assign next_pinClean = (stageTwo == stageThree) ? stageThree : pinClean;

   // Stage one is read only by stage two
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         stageOne   <= '0;
         stageTwo   <= '0;
         stageThree <= '0;
         pinClean   <= '0;
      end
      else
      begin
         stageOne   <= pinRaw;
         stageTwo   <= stageOne;
         stageThree <= stageTwo;
         pinClean   <= next_pinClean;
      end
   end

endmodule : pin_input_filter
`default_nettype wire

/* File: verification/mpin_cfg_monitor.sv */
// Checker for the register port and pin drive of the multipurpose pins
`timescale 1ns/1ps
`default_nettype none
module mpin_cfg_monitor
   import mpin_cfg_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       reset_n,
   input  wire logic [7:0] regPage,
   input  wire logic [7:0] regAddr,
   input  wire logic       regWrite,
   input  wire logic [7:0] regWrData,
   input  wire logic       regRead,
   input  wire logic [7:0] regRdData,
   input  wire logic       regHit,
   input  wire logic [3:0] bidirPinFunction,
   input  wire logic [3:0] outPin1Function,
   input  wire logic [3:0] outPin2Function,
   input  wire logic       bidirPinOut,
   input  wire logic       bidirPinOutEn_n,
   input  wire logic [3:0] outPinLevel,
   input  wire logic [3:0] outPinOutEn_n
);
   // ======================================
   // Decode helpers
   wire logic pg0    = (regPage == PAGE_PIN_REGS);
   wire logic mapped = pg0 && (regAddr inside {[ADDR_OUT_LEVELS:ADDR_IN_FUNCTION_B]});
   wire logic wr29   = regWrite && pg0 && (regAddr == ADDR_OUT_LEVELS);
   wire logic rd29   = regRead && pg0 && (regAddr == ADDR_OUT_LEVELS);
   wire logic rdMon  = regRead && pg0 && (regAddr == ADDR_BIDIR_MONITOR);
   wire logic rdIn   = regRead && pg0 && (regAddr inside {ADDR_IN_FUNCTION_A, ADDR_IN_FUNCTION_B});
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);
   // ======================================
   // Properties
   property p_levelBidir;
      wr29 |-> ##2 bidirPinOut == $past(regWrData[7], 2);
   endproperty
   a_levelBidir: assert property (p_levelBidir) else $error("bidir level not from bit 7");
   property p_levelPin1;
      wr29 ##1 (outPin1Function == 4'h1) |=> outPinLevel[0] == $past(regWrData[6], 2);
   endproperty
   a_levelPin1: assert property (p_levelPin1) else $error("pin one level not from bit 6");
   property p_enBidir;
      $past(reset_n) |-> bidirPinOutEn_n == ($past(bidirPinFunction) != 4'h1);
   endproperty
   a_enBidir: assert property (p_enBidir) else $error("bidir enable wrong");
   property p_enPin1;
      $past(reset_n) |-> outPinOutEn_n[0] == !($past(outPin1Function) inside {[4'h1:4'h4]});
   endproperty
   a_enPin1: assert property (p_enPin1) else $error("pin one enable wrong");
   property p_offPin2;
      $past(reset_n) && ($past(outPin2Function) == 4'h0) |-> !outPinLevel[1] && outPinOutEn_n[1];
   endproperty
   a_offPin2: assert property (p_offPin2) else $error("disabled pin two active");
   property p_hit;
      regRead |=> regHit == $past(mapped);
   endproperty
   a_hit: assert property (p_hit) else $error("read acknowledge wrong");
   property p_rdHold;
      !regRead |=> $stable(regRdData);
   endproperty
   a_rdHold: assert property (p_rdHold) else $error("read data moved without read");
   property p_resvOut;
      rd29 |=> regRdData[2:0] == 3'h0;
   endproperty
   a_resvOut: assert property (p_resvOut) else $error("output levels low bits set");
   property p_resvMon;
      rdMon |=> regRdData[6:0] == 7'h00;
   endproperty
   a_resvMon: assert property (p_resvMon) else $error("monitor low bits set");
   property p_resvIn;
      rdIn |=> !regRdData[7] && !regRdData[3];
   endproperty
   a_resvIn: assert property (p_resvIn) else $error("function reserved bits set");
endmodule : mpin_cfg_monitor

bind multipurpose_pin_config_value mpin_cfg_monitor mpin_cfg_monitor_i (
   .ref_clk(ref_clk), .reset_n(reset_n), .regPage(regPage), .regAddr(regAddr),
   .regWrite(regWrite), .regWrData(regWrData), .regRead(regRead), .regRdData(regRdData),
   .regHit(regHit), .bidirPinFunction(bidirPinFunction), .outPin1Function(outPin1Function),
   .outPin2Function(outPin2Function), .bidirPinOut(bidirPinOut),
   .bidirPinOutEn_n(bidirPinOutEn_n), .outPinLevel(outPinLevel), .outPinOutEn_n(outPinOutEn_n)
);
`default_nettype wire

/* File: verification/multipurpose_pin_config_value_tb.sv */
// Self-checking bench for the multipurpose pin register logic
`timescale 1ns/1ps
`default_nettype none
module multipurpose_pin_config_value_tb
   import mpin_cfg_pkg::*;
;
   logic       ref_clk = 1'b0, reset_n = 1'b0, regWrite = 1'b0, regRead = 1'b0, regHit;
   logic [7:0] regPage = 8'h00, regAddr = 8'h00, regWrData = 8'h00, regRdData;
   logic [3:0] bidirPinFunction = 4'h0, outFn [4] = '{4{4'h0}};
   logic       irqLevel = 1'b1, serialAudio2Out = 1'b0, pdmClockOut = 1'b1;
   logic       bidirPinIn, bidirPinOut, bidirPinOutEn_n, extDrive = 1'b1, extLevel = 1'b0;
   logic [3:0] inPinRaw, outPinLevel, outPinOutEn_n, generalInputLevel, extInLevel = 4'hf;
   logic       controllerClockIn, daisyChainDataInput, routeConflict;
   logic       pdmPair12Data, pdmPair34Data, pdmPair56Data, pdmPair78Data;
   int         errTotal = 0, comparisons = 0;
   wire logic [5:0] roles = {pdmPair78Data, pdmPair56Data, pdmPair34Data, pdmPair12Data,
                             daisyChainDataInput, controllerClockIn};
   typedef struct packed {logic [7:0] pg; logic [7:0] addr; logic [7:0] wdat; logic [7:0] exp;} row_s;
   row_s       rows [7] = '{'{8'h00, 8'h29, 8'hff, 8'hf8}, '{8'h01, 8'h29, 8'h00, 8'hf8},
                            '{8'h00, 8'h2a, 8'hff, 8'h00}, '{8'h00, 8'h2b, 8'hff, 8'h77},
                            '{8'h00, 8'h2c, 8'haa, 8'h22}, '{8'h00, 8'h30, 8'hff, 8'h00},
                            '{8'h00, 8'h29, 8'h07, 8'h00}};
   logic [7:0] expLv [6] = '{8'h00, 8'h0f, 8'h0f, 8'h00, 8'h0f, 8'h00};
   logic [7:0] expEn [6] = '{8'h1f, 8'h00, 8'h10, 8'h10, 8'h10, 8'h1f};

   // ======================================
   // Design, board model and clock
   multipurpose_pin_config_value multipurpose_pin_config_value_i (
      .ref_clk(ref_clk), .reset_n(reset_n), .regPage(regPage), .regAddr(regAddr),
      .regWrite(regWrite), .regWrData(regWrData), .regRead(regRead), .regRdData(regRdData),
      .regHit(regHit), .bidirPinFunction(bidirPinFunction), .outPin1Function(outFn[0]),
      .outPin2Function(outFn[1]), .outPin3Function(outFn[2]), .outPin4Function(outFn[3]),
      .irqLevel(irqLevel), .serialAudio2Out(serialAudio2Out), .pdmClockOut(pdmClockOut),
      .bidirPinIn(bidirPinIn), .bidirPinOut(bidirPinOut), .bidirPinOutEn_n(bidirPinOutEn_n),
      .outPinLevel(outPinLevel), .outPinOutEn_n(outPinOutEn_n), .inPinRaw(inPinRaw),
      .generalInputLevel(generalInputLevel), .controllerClockIn(controllerClockIn),
      .daisyChainDataInput(daisyChainDataInput), .pdmPair12Data(pdmPair12Data),
      .pdmPair34Data(pdmPair34Data), .pdmPair56Data(pdmPair56Data),
      .pdmPair78Data(pdmPair78Data), .routeConflict(routeConflict));
   pin_world_model pin_world_model_i (
      .bidirPinOut(bidirPinOut), .bidirPinOutEn_n(bidirPinOutEn_n), .extDrive(extDrive),
      .extLevel(extLevel), .extInLevel(extInLevel), .bidirPinIn(bidirPinIn),
      .inPinRaw(inPinRaw));
   always #25 ref_clk = ~ref_clk;

   // ======================================
   // Bus tasks and comparison
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         errTotal++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] pg, input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      regPage <= pg;
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge ref_clk);
      regWrite <= 1'b0;
   endtask : wr

   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      regPage <= PAGE_PIN_REGS;
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge ref_clk);
      regRead <= 1'b0;
      #1;
      chk(regRdData, exp);
      chk({7'h0, regHit}, {7'h0, a inside {[ADDR_OUT_LEVELS:ADDR_IN_FUNCTION_B]}});
   endtask : rdc

   task automatic close_out;
      $display("comparisons %0d mismatches %0d", comparisons, errTotal);
      if (errTotal == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : close_out

   // Watchdog against a hung sequence
   initial
   begin
      repeat (5000) @(posedge ref_clk);
      errTotal++;
      close_out();
   end

   // ======================================
   // Main sequence
   initial
   begin
      logic [15:0] cfg;
      repeat (12) @(posedge ref_clk);
      reset_n <= 1'b1;
      foreach (rows[i])
      begin
         wr(rows[i].pg, rows[i].addr, rows[i].wdat);
         rdc(rows[i].addr, rows[i].exp);
      end
      // Levels in general output mode
      @(posedge ref_clk);
      outFn <= '{4{4'h1}};
      bidirPinFunction <= 4'h1;
      wr(PAGE_PIN_REGS, ADDR_OUT_LEVELS, 8'ha8);
      repeat (2) @(posedge ref_clk);
      #1;
      chk({3'h0, bidirPinOut, outPinLevel}, 8'h1a);
      chk({3'h0, bidirPinOutEn_n, outPinOutEn_n}, 8'h00);
      wr(PAGE_PIN_REGS, ADDR_OUT_LEVELS, 8'h50);
      repeat (2) @(posedge ref_clk);
      #1;
      chk({3'h0, bidirPinOut, outPinLevel}, 8'h05);
      // Output function codes 0 to 5
      wr(PAGE_PIN_REGS, ADDR_OUT_LEVELS, 8'hf8);
      for (int f = 0; f < 6; f++)
      begin
         @(posedge ref_clk);
         outFn <= '{4{f[3:0]}};
         bidirPinFunction <= f[3:0];
         repeat (2) @(posedge ref_clk);
         #1;
         chk({4'h0, outPinLevel}, expLv[f]);
         chk({3'h0, bidirPinOutEn_n, outPinOutEn_n}, expEn[f]);
      end
      // Every input code on every pin
      for (int c = 0; c < 8; c++)
         for (int p = 0; p < 4; p++)
         begin
            cfg = 16'(c) << (12 - 4 * p);
            wr(PAGE_PIN_REGS, ADDR_IN_FUNCTION_A, cfg[15:8]);
            wr(PAGE_PIN_REGS, ADDR_IN_FUNCTION_B, cfg[7:0]);
            repeat (3) @(posedge ref_clk);
            #1;
            chk({4'h0, generalInputLevel}, (c == 1) ? 8'(1 << p) : 8'h00);
            chk({1'h0, routeConflict, roles}, (c >= 2) ? 8'(1 << (c - 2)) : 8'h00);
         end
      wr(PAGE_PIN_REGS, ADDR_IN_FUNCTION_A, 8'h70);
      extInLevel <= 4'h7;
      repeat (6) @(posedge ref_clk);
      #1;
      chk({6'h0, routeConflict, pdmPair78Data}, 8'h03);
      // Bidir monitor and its synchroniser delay
      @(posedge ref_clk);
      bidirPinFunction <= BIDIR_FUNC_INPUT;
      repeat (8) @(posedge ref_clk);
      rdc(ADDR_BIDIR_MONITOR, 8'h00);
      @(posedge ref_clk);
      extLevel <= 1'b1;
      rdc(ADDR_BIDIR_MONITOR, 8'h00);
      repeat (6) @(posedge ref_clk);
      rdc(ADDR_BIDIR_MONITOR, 8'h80);
      // Mid-run reset clears every register
      @(posedge ref_clk);
      reset_n <= 1'b0;
      repeat (4) @(posedge ref_clk);
      reset_n <= 1'b1;
      rdc(ADDR_BIDIR_MONITOR, 8'h00);
      rdc(ADDR_OUT_LEVELS, 8'h00);
      rdc(ADDR_IN_FUNCTION_A, 8'h00);
      rdc(ADDR_IN_FUNCTION_B, 8'h00);
      close_out();
   end
endmodule : multipurpose_pin_config_value_tb
`default_nettype wire

/* File: verification/pin_world_model.sv */
// Board-side model of the wiring on the multipurpose pins
`timescale 1ns/1ps
`default_nettype none
module pin_world_model (
   input  wire logic       bidirPinOut,
   input  wire logic       bidirPinOutEn_n,
   input  wire logic       extDrive,
   input  wire logic       extLevel,
   input  wire logic [3:0] extInLevel,
   output var  logic       bidirPinIn,
   output var  logic [3:0] inPinRaw
);
   // Wire level: device driver, then board driver, else the pull-up
   always_comb
   begin
      if (!bidirPinOutEn_n)
         bidirPinIn = bidirPinOut;
      else if (extDrive)
         bidirPinIn = extLevel;
      else
         bidirPinIn = 1'b1;
      inPinRaw = extInLevel;
   end
endmodule : pin_world_model
`default_nettype wire
